// *** rtl/pwd_timer_io_consts.svh ***
// constants for the timer pin routing and pulse-width demodulation block
`ifndef PWD_TIMER_IO_CONSTS_SVH
`define PWD_TIMER_IO_CONSTS_SVH

`define PWD_SYNC_STAGES   2
`define PWD_OE_RELEASED   1'b0
`define PWD_OE_DRIVEN     1'b1
`define PWD_OUT_RST_LEVEL 1'b0

`endif

// *** rtl/pwd_timer_io_pkg.sv ***
// types for the timer pin routing and pulse-width demodulation block
package pwd_timer_io_pkg;

  typedef enum logic [0:0] {
    PWD_MODE_TIMER = 1'b0,
    PWD_MODE_DEMOD = 1'b1
  } pwd_mode_e;

endpackage

// *** rtl/pwd_sync_edge.sv ***
// two-stage synchroniser with rising and falling edge detection
`timescale 1ns/100ps
`include "pwd_timer_io_consts.svh"

module pwd_sync_edge #(
  parameter int STAGES = `PWD_SYNC_STAGES
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  if (STAGES != 2) begin : g_bad_stages
    $error("pwd_sync_edge supports exactly two synchroniser stages");
  end

  // meta_q feeds sync_q only; edges are taken after the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // preload the pin level: a pin that idles high must not tick on release
      meta_q <= pin_in;
      sync_q <= pin_in;
      prev_q <= pin_in;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;

endmodule

// *** rtl/pwd_timer_io.sv ***
// timer input/output pin routing with pulse-width demodulation
`timescale 1ns/100ps
`include "pwd_timer_io_consts.svh"

module pwd_timer_io (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire pwd_timer_io_pkg::pwd_mode_e demod_mode,
  input  wire logic                  pulse_width_demod_input,
  input  wire logic                  timer_input_zero,
  input  wire logic                  timer_input_one,
  input  wire logic                  ext_irq_seven,
  input  wire logic                  prog_io_en_zero,
  input  wire logic                  prog_io_en_one,
  input  wire logic                  bus_hold,
  input  wire logic                  timer_wave_zero,
  input  wire logic                  timer_wave_one,
  output logic                       timer_zero_tick_q,
  output logic                       timer_one_tick_q,
  output logic                       ext_irq_eight_q,
  output logic                       irq_chan_seven_q,
  output logic                       prog_io_pin_zero_q,
  output logic                       prog_io_pin_one_q,
  output logic                       pullup_zero_q,
  output logic                       pullup_one_q,
  output logic                       timer_output_zero_q,
  output logic                       timer_output_zero_oe_q,
  output logic                       timer_output_one_q,
  output logic                       timer_output_one_oe_q
);
  import pwd_timer_io_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic pwd_level;
  logic pwd_rise;
  logic pwd_fall;
  logic t0_level;
  logic t0_rise;
  logic t1_level;
  logic t1_rise;
  logic i7_level;

  pwd_sync_edge u_sync_pwd (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (pulse_width_demod_input),
    .level    (pwd_level),
    .rise     (pwd_rise),
    .fall     (pwd_fall)
  );

  pwd_sync_edge u_sync_t0 (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (timer_input_zero),
    .level    (t0_level),
    .rise     (t0_rise),
    .fall     ()
  );

  pwd_sync_edge u_sync_t1 (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (timer_input_one),
    .level    (t1_level),
    .rise     (t1_rise),
    .fall     ()
  );

  pwd_sync_edge u_sync_i7 (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (ext_irq_seven),
    .level    (i7_level),
    .rise     (),
    .fall     ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // routing

  wire demod_on     = (demod_mode == PWD_MODE_DEMOD);
  // a rising edge of the inverted input is a falling edge of the input
  wire t0_tick_w    = demod_on ? pwd_rise : t0_rise;
  wire t1_tick_w    = demod_on ? pwd_fall : t1_rise;
  wire demod_irq_w  = demod_on & ~pwd_level;
  // level sources are or-ed, so either one holds the shared channel active
  wire chan_seven_w = i7_level | demod_irq_w;
  wire drive_ok_w   = ~bus_hold;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_zero_tick_q  <= 1'b0;
      timer_one_tick_q   <= 1'b0;
      ext_irq_eight_q    <= 1'b0;
      irq_chan_seven_q   <= 1'b0;
    end else begin
      timer_zero_tick_q  <= t0_tick_w;
      timer_one_tick_q   <= t1_tick_w;
      ext_irq_eight_q    <= pwd_level;
      irq_chan_seven_q   <= chan_seven_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer pins used as programmable I/O

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pullup_zero_q      <= 1'b0;
      pullup_one_q       <= 1'b0;
      prog_io_pin_zero_q <= 1'b0;
      prog_io_pin_one_q  <= 1'b0;
    end else begin
      pullup_zero_q      <= prog_io_en_zero;
      pullup_one_q       <= prog_io_en_one;
      prog_io_pin_zero_q <= prog_io_en_zero & t0_level;
      prog_io_pin_one_q  <= prog_io_en_one & t1_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer output pins

  // the waveform itself is shaped by the timer; here it is only registered, and its output enable gated by bus_hold
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_output_zero_q    <= `PWD_OUT_RST_LEVEL;
      timer_output_one_q     <= `PWD_OUT_RST_LEVEL;
      timer_output_zero_oe_q <= `PWD_OE_RELEASED;
      timer_output_one_oe_q  <= `PWD_OE_RELEASED;
    end else begin
      timer_output_zero_q    <= timer_wave_zero;
      timer_output_one_q     <= timer_wave_one;
      timer_output_zero_oe_q <= drive_ok_w;
      timer_output_one_oe_q  <= drive_ok_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_pin0_rise;
    !demod_on && !timer_input_zero ##1 !demod_on && timer_input_zero ##1 !demod_on ##1 !demod_on;
  endsequence

  property p_demod_t0;
    @(posedge core_clk) disable iff (rst)
      demod_on && pwd_rise |=> timer_zero_tick_q;
  endproperty
  a_demod_t0: assert property (p_demod_t0) else $error("demod rise did not tick timer 0");

  property p_demod_t1;
    @(posedge core_clk) disable iff (rst)
      demod_on && pwd_fall |=> timer_one_tick_q && !timer_zero_tick_q;
  endproperty
  a_demod_t1: assert property (p_demod_t1) else $error("demod fall did not tick timer 1");

  property p_pins_ignored;
    @(posedge core_clk) disable iff (rst)
      demod_on && !pwd_rise && !pwd_fall |=> !timer_zero_tick_q && !timer_one_tick_q;
  endproperty
  a_pins_ignored: assert property (p_pins_ignored) else $error("timer pin leaked in demod");

  property p_shared_chan;
    @(posedge core_clk) disable iff (rst)
      demod_on && !pwd_level |=> irq_chan_seven_q && !ext_irq_eight_q;
  endproperty
  a_shared_chan: assert property (p_shared_chan) else $error("demod irq missing on chan 7");

  property p_sync_tick;
    @(posedge core_clk) disable iff (rst)
      s_pin0_rise |=> timer_zero_tick_q;
  endproperty
  a_sync_tick: assert property (p_sync_tick) else $error("synced pin edge gave no tick");

  property p_pullup;
    @(posedge core_clk) disable iff (rst)
      prog_io_en_zero && prog_io_en_one |=> pullup_zero_q && pullup_one_q;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not applied to I/O pin");

  property p_wave;
    @(posedge core_clk) disable iff (rst)
      !bus_hold |=> timer_output_zero_oe_q && timer_output_zero_q == $past(timer_wave_zero)
        && timer_output_one_q == $past(timer_wave_one);
  endproperty
  a_wave: assert property (p_wave) else $error("timer waveform not driven");

  property p_hold_float;
    @(posedge core_clk) disable iff (rst)
      bus_hold |=> !timer_output_zero_oe_q && !timer_output_one_oe_q;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("timer outputs driven in hold");

  property p_normal_route;
    @(posedge core_clk) disable iff (rst)
      !demod_on && t1_rise && !i7_level |=> timer_one_tick_q && !irq_chan_seven_q;
  endproperty
  a_normal_route: assert property (p_normal_route) else $error("own pin not routed");

  property p_irq_eight;
    @(posedge core_clk) disable iff (rst)
      1'b1 |=> ext_irq_eight_q == $past(pwd_level);
  endproperty
  a_irq_eight: assert property (p_irq_eight) else $error("irq eight not following pin");

  property p_io_read;
    @(posedge core_clk) disable iff (rst)
      prog_io_en_zero |=> prog_io_pin_zero_q == $past(t0_level);
  endproperty
  a_io_read: assert property (p_io_read) else $error("I/O pin level not readable");

  property p_io_idle;
    @(posedge core_clk) disable iff (rst)
      !prog_io_en_one |=> !prog_io_pin_one_q && !pullup_one_q;
  endproperty
  a_io_idle: assert property (p_io_idle) else $error("I/O pin active while disabled");

  property p_reset_float;
    @(posedge core_clk)
      rst |=> !timer_output_zero_oe_q && !timer_output_one_oe_q;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("timer outputs driven in reset");

endmodule

// *** tb/pwd_pulse_src.sv ***
// pin-side source model for the timer and demodulator inputs
`timescale 1ns/100ps
module pwd_pulse_src (
  input  wire logic       core_clk,
  input  wire logic       slow,
  input  wire logic [3:0] rnd,
  output logic            pulse_width_demod_input,
  output logic            timer_input_zero,
  output logic            timer_input_one,
  output logic            ext_irq_seven
);
  logic [2:0] hold_q;
  initial {pulse_width_demod_input, timer_input_zero, timer_input_one, ext_irq_seven} = '0;
  initial hold_q = '0;
  // pins move just after the edge, so every level spans whole cycles and is seen
  always @(posedge core_clk) begin
    hold_q <= hold_q + 3'h1;
    if (!slow || hold_q == 3'h0) begin
      {pulse_width_demod_input, timer_input_zero, timer_input_one, ext_irq_seven} <= #1 rnd;
    end
  end
endmodule

// *** tb/pwd_timer_io_tb.sv ***
// self-checking bench for the timer pin routing block
`timescale 1ns/100ps
module pwd_timer_io_tb;
  import pwd_timer_io_pkg::*;
  logic core_clk = 0, rst = 1, bus_hold = 0, timer_wave_zero = 0, timer_wave_one = 0;
  logic prog_io_en_zero = 0, prog_io_en_one = 0, slow = 0, rst_q = 0;
  pwd_mode_e demod_mode = PWD_MODE_TIMER;
  logic pulse_width_demod_input, timer_input_zero, timer_input_one, ext_irq_seven;
  logic timer_zero_tick_q, timer_one_tick_q, ext_irq_eight_q, irq_chan_seven_q;
  logic prog_io_pin_zero_q, prog_io_pin_one_q, pullup_zero_q, pullup_one_q;
  logic timer_output_zero_q, timer_output_zero_oe_q, timer_output_one_q, timer_output_one_oe_q;
  logic [3:0]  rnd = '0;
  logic [7:0]  lf = 8'h2f;
  logic [2:0]  sp, s0, s1, s7;
  logic [11:0] ex, got;
  int bad_count = 0, compares = 0, live = 0, n0 = 0, n1 = 0;
  always #2 core_clk = ~core_clk;
  pwd_pulse_src i_pwd_pulse_src (.core_clk, .slow, .rnd, .pulse_width_demod_input,
    .timer_input_zero, .timer_input_one, .ext_irq_seven);
  pwd_timer_io i_pwd_timer_io (.core_clk, .rst, .demod_mode, .pulse_width_demod_input,
    .timer_input_zero, .timer_input_one, .ext_irq_seven, .prog_io_en_zero, .prog_io_en_one,
    .bus_hold, .timer_wave_zero, .timer_wave_one, .timer_zero_tick_q, .timer_one_tick_q,
    .ext_irq_eight_q, .irq_chan_seven_q, .prog_io_pin_zero_q, .prog_io_pin_one_q,
    .pullup_zero_q, .pullup_one_q, .timer_output_zero_q, .timer_output_zero_oe_q,
    .timer_output_one_q, .timer_output_one_oe_q);
  assign got = {timer_zero_tick_q, timer_one_tick_q, ext_irq_eight_q, irq_chan_seven_q,
    prog_io_pin_one_q, prog_io_pin_zero_q, pullup_one_q, pullup_zero_q,
    timer_output_zero_q, timer_output_zero_oe_q, timer_output_one_q, timer_output_one_oe_q};
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // p/a/b/c: demod, timer zero, timer one, irq seven pins through the sync stages
  function automatic logic [11:0] expect_out(logic d, logic [2:0] p, a, b, c,
                                             logic [1:0] en, logic h, logic [1:0] w);
    logic up0, up1;
    up0 = d ? (p[1] & ~p[2]) : (a[1] & ~a[2]);
    up1 = d ? (p[2] & ~p[1]) : (b[1] & ~b[2]);
    return {up0, up1, p[1], c[1] | (d & ~p[1]), en[1] & b[1], en[0] & a[1], en,
            w[0], ~h, w[1], ~h};
  endfunction
  always @(posedge core_clk) begin
    rst_q <= rst;
    if (rst) begin
      sp <= {3{pulse_width_demod_input}};
      s0 <= {3{timer_input_zero}};
      s1 <= {3{timer_input_one}};
      s7 <= {3{ext_irq_seven}};
      ex <= '0;
    end else begin
      sp <= {sp[1:0], pulse_width_demod_input};
      s0 <= {s0[1:0], timer_input_zero};
      s1 <= {s1[1:0], timer_input_one};
      s7 <= {s7[1:0], ext_irq_seven};
      ex <= expect_out(demod_mode == PWD_MODE_DEMOD, sp, s0, s1, s7,
                       {prog_io_en_one, prog_io_en_zero}, bus_hold,
                       {timer_wave_one, timer_wave_zero});
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic g, input logic e, input string what);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t %s got %b exp %b", $time, what, g, e);
    end
  endtask
  always @(negedge core_clk) begin
    if (rst_q) chk(timer_output_zero_oe_q | timer_output_one_oe_q, 1'b0, "oe in reset");
    if (live >= 4) begin
      chk(got[11], ex[11], "tick zero");
      chk(got[10], ex[10], "tick one");
      chk(got[9], ex[9], "irq eight");
      chk(got[8], ex[8], "chan seven");
      chk(got[7], ex[7], "io one");
      chk(got[6], ex[6], "io zero");
      chk(got[5], ex[5], "pullup one");
      chk(got[4], ex[4], "pullup zero");
      chk(got[3], ex[3], "wave zero");
      chk(got[1], ex[1], "wave one");
      chk(got[2], ex[2], "oe zero");
      chk(got[0], ex[0], "oe one");
      if (demod_mode == PWD_MODE_DEMOD) begin
        n0 += int'(timer_zero_tick_q);
        n1 += int'(timer_one_tick_q);
        chk(n0 - n1 <= 1 && n1 - n0 <= 1, 1'b1, "tick balance");
      end
    end
    live++;
  end
  task run(input pwd_mode_e m, input logic [1:0] en, input logic s, input int n);
    @(posedge core_clk);
    #1 demod_mode = m;
    {prog_io_en_one, prog_io_en_zero, slow} = {en, s};
    live = 0;
    n0 = 0;
    n1 = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1 lf = lfsr(lf);
      {timer_wave_one, timer_wave_zero, bus_hold, rnd} = {lf[7:6], lf[5] & lf[4], lf[3:0]};
    end
  endtask
  task close_out;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst = 0;
    run(PWD_MODE_TIMER, 2'b00, 1'b0, 400);
    run(PWD_MODE_TIMER, 2'b11, 1'b1, 300);
    run(PWD_MODE_DEMOD, 2'b00, 1'b1, 400);
    run(PWD_MODE_DEMOD, 2'b11, 1'b0, 300);
    @(posedge core_clk);
    #1 rst = 1;
    repeat (3) @(posedge core_clk);
    #1 rst = 0;
    run(PWD_MODE_DEMOD, 2'b01, 1'b0, 300);
    run(PWD_MODE_TIMER, 2'b10, 1'b1, 300);
    close_out;
  end
endmodule
